//--- rtl/prp_metering.sv
// Per-phase power, energy, power factor and rms datapath with an AXI4-Lite register slave.
`timescale 1ns/1ns
`include "prp_map.svh"
module prp_metering (
  // Clock, reset and enable.
  input wire logic mclk,
  input wire logic nrst,
  input wire logic clkEn,
  // Corrected waveforms and instantaneous power per phase.
  input prp_pkg::prp_phase_s phaseIn [3],
  input prp_pkg::prp_word_t neutralCorrectedWaveform,
  input prp_pkg::prp_power_s powerIn [3],
  input wire logic lineCycle,
  // AXI4-Lite slave.
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Interrupt and sample strobe.
  output logic irq,
  output logic dspTick
);
  localparam int NCH = 8;
  logic [31:0] divCnt_q;
  logic [11:0] pfCnt_q, pwrCnt_q, epCnt_q;
  wire tick = clkEn && (divCnt_q == 32'(`PRP_DSP_DIV - 1));
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) divCnt_q <= 32'h0;
    else if (clkEn) divCnt_q <= tick ? 32'h0 : divCnt_q + 32'h1;
  end
  assign dspTick = tick;

  // Registers written by software.
  logic [31:0] config_q, pwrTime_q, epCfg_q, epTime_q, current_sum_threshold_q, irqEn_q;
  logic [31:0] rmsOs_q [NCH];
  logic [3:0] status_q;
  prp_pkg::prp_sum_e sumSel;
  assign sumSel = prp_pkg::prp_sum_e'(config_q[1:0]);

  // Channel waveforms: 0..2 currents, 3 neutral, 4..6 voltages, 7 current sum.
  logic signed [33:0] isum;
  prp_pkg::prp_word_t chWave [NCH];
  always_comb begin
    isum = 34'(phaseIn[0].cur) + 34'(phaseIn[1].cur) + 34'(phaseIn[2].cur);
    case (sumSel)
      prp_pkg::SUM_ADD_NEUTRAL: isum = isum + 34'(neutralCorrectedWaveform);
      prp_pkg::SUM_SUB_NEUTRAL: isum = isum - 34'(neutralCorrectedWaveform);
      default: isum = isum;
    endcase
  end
  assign chWave[3] = neutralCorrectedWaveform;
  assign chWave[7] = isum[33:2];

  // Rms channels: square, low-pass, offset, root (results at unity gain, PRP_RMS_FS not applied).
  logic [31:0] rms_q [NCH];
  logic [31:0] rmsNew [NCH];
  generate
    for (genvar c = 0; c < NCH; c++) begin : gRms
      if (c < 3) begin : gCur
        assign chWave[c] = phaseIn[c].cur;
      end else if (c >= 4 && c < 7) begin : gVolt
        assign chWave[c] = phaseIn[c - 4].volt;
      end
      logic [63:0] sq, lpf_q, corr;
      logic [31:0] root;
      assign sq = 64'($signed(chWave[c])) * 64'($signed(chWave[c]));
      // Single-stage low-pass: one-pole IIR of the square.
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) lpf_q <= 64'h0;
        else if (tick) lpf_q <= lpf_q - (lpf_q >> `PRP_LPF_SHIFT) + (sq >> `PRP_LPF_SHIFT);
      end
      // Offset adds the register times 2^15 to the squared result.
      assign corr = lpf_q + (64'($signed(rmsOs_q[c])) <<< `PRP_OS_SHIFT);
      always_comb begin
        logic [63:0] rem;
        rem = corr;
        root = 32'h0;
        for (int b = 31; b >= 0; b--) begin
          if (rem >= 64'({root | (32'h1 << b)}) * 64'({root | (32'h1 << b)}))
            root = root | (32'h1 << b);
        end
      end
      // No squelch: small residue passes through unaltered.
      assign rmsNew[c] = corr[63] ? 32'h0 : root;
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) rms_q[c] <= 32'h0;
        else if (tick) rms_q[c] <= rmsNew[c];
      end
    end
  endgenerate

  // Mismatch detector on sum rms versus threshold.
  logic above_q;
  wire aboveNow = rmsNew[7] > current_sum_threshold_q;
  wire mismatchEv = tick && (aboveNow != above_q);
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) above_q <= 1'b0;
    else if (tick) above_q <= aboveNow;
  end

  // Power, energy and power factor per phase.
  logic [31:0] pwr_q [3][4];
  logic [31:0] acc_q [3];
  logic signed [`PRP_ACC_W-1:0] pAcc_q [3], nrg_q [3], eAcc_q [3];
  logic [31:0] pf_q [3];
  logic [`PRP_ACC_W+1:0] pfAct_q [3], pfApp_q [3];
  wire pwrDone = tick && (pwrCnt_q >= pwrTime_q[11:0]);
  wire epStep = epCfg_q[`PRP_EP_LINE] ? lineCycle : tick;
  wire epDone = epCfg_q[`PRP_EP_MODE] ? (epStep && epCnt_q >= epTime_q[11:0]) : tick;
  wire pfDone = tick && (pfCnt_q == 12'(`PRP_PF_SAMPLES - 1));
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pwrCnt_q <= 12'h0;
      epCnt_q <= 12'h0;
      pfCnt_q <= 12'h0;
    end else begin
      if (tick) pwrCnt_q <= pwrDone ? 12'h0 : pwrCnt_q + 12'h1;
      if (epStep && clkEn) epCnt_q <= epDone ? 12'h0 : epCnt_q + 12'h1;
      if (tick) pfCnt_q <= pfCnt_q + 12'h1;
    end
  end
  generate
    for (genvar p = 0; p < 3; p++) begin : gPh
      wire signed [`PRP_ACC_W-1:0] act = `PRP_ACC_W'(powerIn[p].active);
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          for (int k = 0; k < 4; k++) pwr_q[p][k] <= 32'h0;
          acc_q[p] <= 32'h0;
          pAcc_q[p] <= '0;
          eAcc_q[p] <= '0;
          nrg_q[p] <= '0;
          pf_q[p] <= 32'h0;
          pfAct_q[p] <= '0;
          pfApp_q[p] <= '0;
        end else if (tick) begin
          pwr_q[p][0] <= powerIn[p].active;
          pwr_q[p][1] <= powerIn[p].reactive;
          pwr_q[p][2] <= powerIn[p].apparent;
          pwr_q[p][3] <= powerIn[p].fundReactive;
          pAcc_q[p] <= pwrDone ? '0 : pAcc_q[p] + act;
          if (pwrDone) acc_q[p] <= 32'(pAcc_q[p] + act);
          eAcc_q[p] <= epDone ? '0 : eAcc_q[p] + act;
          if (epDone) nrg_q[p] <= nrg_q[p] + eAcc_q[p] + act;
          pfAct_q[p] <= pfDone ? '0 : pfAct_q[p] + (`PRP_ACC_W+2)'(act);
          pfApp_q[p] <= pfDone ? '0 : pfApp_q[p] + (`PRP_ACC_W+2)'(powerIn[p].apparent);
          // Power factor in Q27: active over apparent summed over the window.
          if (pfDone) pf_q[p] <= (pfApp_q[p] == '0) ? 32'h0 :
            32'(({pfAct_q[p], 27'h0}) / {27'h0, pfApp_q[p]});
        end
      end
    end
  endgenerate

  // AXI4-Lite write path: address and data taken in either order.
  logic awHave_q, wHave_q;
  logic [7:0] awAddr_q;
  logic [31:0] wData_q;
  assign awready = !awHave_q && !bvalid;
  assign wready = !wHave_q && !bvalid;
  wire wrGo = awHave_q && wHave_q && !bvalid;
  wire [5:0] wIdx = awAddr_q[7:2];
  wire wrOs = wIdx >= 6'(`PRP_REG_OS_BASE >> 2) && wIdx < 6'((`PRP_REG_OS_BASE >> 2) + NCH);
  wire wrOk = wrOs || awAddr_q <= `PRP_REG_IRQEN && awAddr_q != `PRP_REG_STATUS;
  logic [3:0] clrMask;
  assign clrMask = (wrGo && awAddr_q == `PRP_REG_STCLR) ? wData_q[3:0] : 4'h0;
  wire [3:0] events = {pfDone, epDone, pwrDone, mismatchEv};
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      awHave_q <= 1'b0;
      wHave_q <= 1'b0;
      awAddr_q <= 8'h0;
      wData_q <= 32'h0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      config_q <= 32'h0;
      pwrTime_q <= `PRP_PWRTIME_RST;
      epCfg_q <= 32'h0;
      epTime_q <= `PRP_EPTIME_RST;
      current_sum_threshold_q <= 32'h0;
      irqEn_q <= 32'h0;
      status_q <= 4'h0;
      for (int i = 0; i < NCH; i++) rmsOs_q[i] <= 32'h0;
    end else if (clkEn) begin
      if (awvalid && awready) begin
        awHave_q <= 1'b1;
        awAddr_q <= awaddr;
      end
      if (wvalid && wready) begin
        wHave_q <= 1'b1;
        wData_q <= wdata;
      end
      status_q <= (status_q & ~clrMask) | events;
      if (wrGo) begin
        awHave_q <= 1'b0;
        wHave_q <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wrOk ? `PRP_RESP_OKAY : `PRP_RESP_SLVERR;
        case (awAddr_q)
          `PRP_REG_CONFIG: config_q <= wData_q;
          `PRP_REG_PWRTIME: pwrTime_q <= wData_q;
          `PRP_REG_EPCFG: epCfg_q <= wData_q;
          `PRP_REG_EPTIME: epTime_q <= wData_q;
          `PRP_REG_CURRENT_SUM_THRESHOLD: current_sum_threshold_q <= wData_q;
          `PRP_REG_IRQEN: irqEn_q <= wData_q;
          default: if (wrOs) rmsOs_q[3'(wIdx)] <= wData_q;
        endcase
      end else if (bvalid && bready) bvalid <= 1'b0;
    end
  end
  assign irq = |(status_q & irqEn_q[3:0]);

  // AXI4-Lite read path: answer one cycle after the address is taken.
  wire [7:0] ra = araddr;
  wire [5:0] rIdx = ra[7:2];
  logic [31:0] rVal;
  logic rOk;
  always_comb begin
    rOk = 1'b1;
    rVal = 32'h0;
    case (ra)
      `PRP_REG_CONFIG: rVal = config_q;
      `PRP_REG_PWRTIME: rVal = pwrTime_q;
      `PRP_REG_EPCFG: rVal = epCfg_q;
      `PRP_REG_EPTIME: rVal = epTime_q;
      `PRP_REG_CURRENT_SUM_THRESHOLD: rVal = current_sum_threshold_q;
      `PRP_REG_STATUS: rVal = {28'h0, status_q};
      `PRP_REG_STCLR: rVal = 32'h0;
      `PRP_REG_IRQEN: rVal = irqEn_q;
      default: begin
        if (ra >= `PRP_REG_OS_BASE && ra < `PRP_REG_IRMS_BASE) rVal = rmsOs_q[3'(rIdx)];
        else if (ra >= `PRP_REG_IRMS_BASE && ra < `PRP_REG_PWR_BASE) rVal = rms_q[3'(rIdx)];
        else if (ra >= `PRP_REG_PWR_BASE && ra < `PRP_REG_ACC_BASE)
          rVal = pwr_q[2'((rIdx - 6'h18) >> 2)][2'(rIdx)];
        else if (ra >= `PRP_REG_ACC_BASE && ra < `PRP_REG_ACC_BASE + 8'h0C)
          rVal = acc_q[2'(rIdx - 6'h24)];
        else if (ra >= `PRP_REG_NRG_BASE && ra < `PRP_REG_NRG_BASE + 8'h0C)
          rVal = nrg_q[2'(rIdx - 6'h28)][`PRP_ACC_W-1:`PRP_ACC_W-32];
        else if (ra >= `PRP_REG_PF_BASE && ra < `PRP_REG_PF_BASE + 8'h0C)
          rVal = pf_q[2'(rIdx - 6'h2C)];
        else rOk = 1'b0;
      end
    endcase
  end
  assign arready = !rvalid;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= 2'h0;
    end else if (clkEn) begin
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata <= rVal;
        rresp <= rOk ? `PRP_RESP_OKAY : `PRP_RESP_SLVERR;
      end else if (rvalid && rready) rvalid <= 1'b0;
    end
  end
endmodule : prp_metering

//--- common/prp_map.svh
// Register offsets, field positions, reset values and timing counts of the metering block.
`ifndef PRP_MAP_SVH
`define PRP_MAP_SVH
`define PRP_CLK_MHZ 250
`define PRP_DSP_KSPS 4
`define PRP_DSP_DIV ((`PRP_CLK_MHZ * 1000) / `PRP_DSP_KSPS)
`define PRP_PF_SAMPLES 4096
`define PRP_RMS_FS 52866837
`define PRP_OS_SHIFT 15
`define PRP_LPF_SHIFT 6
`define PRP_ENERGY_SEC 211
`define PRP_ACC_W 48
`define PRP_REG_CONFIG 8'h00
`define PRP_REG_PWRTIME 8'h04
`define PRP_REG_EPCFG 8'h08
`define PRP_REG_EPTIME 8'h0C
`define PRP_REG_CURRENT_SUM_THRESHOLD 8'h10
`define PRP_REG_STATUS 8'h14
`define PRP_REG_STCLR 8'h18
`define PRP_REG_IRQEN 8'h1C
`define PRP_REG_OS_BASE 8'h20
`define PRP_REG_IRMS_BASE 8'h40
`define PRP_REG_PWR_BASE 8'h60
`define PRP_REG_ACC_BASE 8'h90
`define PRP_REG_NRG_BASE 8'hA0
`define PRP_REG_PF_BASE 8'hB0
`define PRP_PWRTIME_RST 32'h0000_00FF
`define PRP_EPTIME_RST 32'h0000_0FFF
`define PRP_ST_MISMATCH 0
`define PRP_ST_PWRRDY 1
`define PRP_ST_NRGRDY 2
`define PRP_ST_PFRDY 3
`define PRP_EP_MODE 0
`define PRP_EP_LINE 1
`define PRP_RESP_OKAY 2'h0
`define PRP_RESP_SLVERR 2'h2
`endif

//--- common/prp_pkg.sv
// Types shared by the metering block.
package prp_pkg;
  typedef logic signed [31:0] prp_word_t;
  typedef struct packed {
    prp_word_t cur;
    prp_word_t volt;
  } prp_phase_s;
  typedef struct packed {
    prp_word_t active;
    prp_word_t reactive;
    prp_word_t apparent;
    prp_word_t fundReactive;
  } prp_power_s;
  typedef enum logic [1:0] {
    SUM_PHASES = 2'b00,
    SUM_ADD_NEUTRAL = 2'b01,
    SUM_SUB_NEUTRAL = 2'b10,
    SUM_PHASES_ALT = 2'b11
  } prp_sum_e;
  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_RESP = 2'b01
  } prp_wr_e;
endpackage : prp_pkg

//--- testbench/prp_metering_properties.sv
// Bus handshake and sample strobe properties of the metering block.
`timescale 1ns/1ns
`include "prp_map.svh"
module prp_metering_properties (
  // Clock, reset and enable.
  input wire logic mclk,
  input wire logic nrst,
  input wire logic clkEn,
  // Register bus.
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  // Sample strobe.
  input wire logic dspTick
);
  logic [16:0] tickCnt_q;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  // Counts enabled cycles since reset or since the last sample strobe.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tickCnt_q <= '0;
    end else if (clkEn) begin
      tickCnt_q <= dspTick ? '0 : tickCnt_q + 17'h1;
    end
  end
  bHold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  rHold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read response dropped early");
  rBusy_a: assert property (rvalid |-> !arready)
    else $error("read address accepted during response");
  bBusy_a: assert property (bvalid |-> !awready && !wready)
    else $error("write accepted during response");
  rLat_a: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  statusWr_a: assert property (awvalid && awready && wvalid && wready
    && awaddr == `PRP_REG_STATUS && clkEn |-> ##2 bvalid && bresp == `PRP_RESP_SLVERR)
    else $error("status write not refused");
  holeRd_a: assert property (arvalid && arready && araddr == 8'hFC |=> rresp == `PRP_RESP_SLVERR)
    else $error("unmapped read not refused");
  tickPulse_a: assert property (dspTick && clkEn |=> !dspTick)
    else $error("sample strobe longer than one cycle");
  tickGap_a: assert property (dspTick && clkEn |-> tickCnt_q == `PRP_DSP_DIV - 1)
    else $error("sample strobe spacing wrong");
  cover property (awvalid && awready && wvalid && wready);
  cover property (arvalid && arready);
  cover property (dspTick);
endmodule : prp_metering_properties

//--- testbench/prp_metering_tb.sv
// Self-checking bench for the metering block.
`timescale 1ns/1ns
`include "prp_map.svh"
module prp_metering_tb;
  logic mclk, nrst, clkEn, lineCycle, irq, dspTick;
  prp_pkg::prp_phase_s phaseIn [3];
  prp_pkg::prp_word_t neutralCorrectedWaveform;
  prp_pkg::prp_power_s powerIn [3];
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, rd0;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp;
  int failures, num_checks;
  prp_metering prp_metering_i (.mclk, .nrst, .clkEn, .phaseIn, .neutralCorrectedWaveform,
    .powerIn, .lineCycle, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .irq, .dspTick);
  initial begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end
  task automatic final_report();
    if (failures == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report
  task automatic hang();
    failures++;
    $display("unexpected at %0t: wait ran out", $time);
    final_report();
  endtask : hang
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic tA, tW, tB;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (int n = 0; n < 50; n++) begin
      @(negedge mclk);
      tA = awvalid && awready;
      tW = wvalid && wready;
      tB = bvalid;
      r = bresp;
      @(posedge mclk);
      if (tA) awvalid <= 1'h0;
      if (tW) wvalid <= 1'h0;
      if (tB) begin
        bready <= 1'h0;
        return;
      end
    end
    hang();
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic tA, tR;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (int n = 0; n < 50; n++) begin
      @(negedge mclk);
      tA = arvalid && arready;
      tR = rvalid;
      d = rdata;
      r = rresp;
      @(posedge mclk);
      if (tA) arvalid <= 1'h0;
      if (tR) begin
        rready <= 1'h0;
        return;
      end
    end
    hang();
  endtask : rd
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    rd(a, rd0, rsp);
    chk(rd0, exp);
  endtask : rdc
  task automatic reset_values();
    rdc(`PRP_REG_PWRTIME, `PRP_PWRTIME_RST);
    rdc(`PRP_REG_EPTIME, `PRP_EPTIME_RST);
    rdc(`PRP_REG_STATUS, 32'h0);
    rd(8'hFC, rd0, rsp);
    chk(32'(rsp), 32'(`PRP_RESP_SLVERR));
    wr(`PRP_REG_STATUS, 32'h1, rsp);
    chk(32'(rsp), 32'(`PRP_RESP_SLVERR));
  endtask : reset_values
  task automatic setup_and_sample();
    wr(`PRP_REG_PWRTIME, 32'h0, rsp);
    wr(`PRP_REG_OS_BASE, 32'h2, rsp);
    wr(`PRP_REG_OS_BASE + 8'h0C, 32'h8, rsp);
    wr(`PRP_REG_OS_BASE + 8'h1C, 32'h2, rsp);
    wr(`PRP_REG_CURRENT_SUM_THRESHOLD, 32'h64, rsp);
    wr(`PRP_REG_IRQEN, 32'h1, rsp);
    for (int n = 0; n <= 70000; n++) begin
      @(negedge mclk);
      if (dspTick === 1'h1) break;
      if (n == 70000) hang();
    end
  endtask : setup_and_sample
  task automatic results();
    rdc(`PRP_REG_PWR_BASE, 32'h0003_0000);
    rdc(`PRP_REG_PWR_BASE + 8'h14, 32'h55);
    rdc(`PRP_REG_ACC_BASE, 32'h0003_0000);
    rdc(`PRP_REG_NRG_BASE, 32'h3);
    rdc(`PRP_REG_IRMS_BASE, 32'h100);
    rdc(`PRP_REG_IRMS_BASE + 8'h04, 32'h0);
    rdc(`PRP_REG_IRMS_BASE + 8'h0C, 32'h200);
    rdc(`PRP_REG_IRMS_BASE + 8'h1C, 32'h100);
    rdc(`PRP_REG_STATUS, 32'h7);
  endtask : results
  task automatic irq_flow();
    @(negedge mclk);
    chk(32'(irq), 32'h1);
    wr(`PRP_REG_IRQEN, 32'h0, rsp);
    @(negedge mclk);
    chk(32'(irq), 32'h0);
    wr(`PRP_REG_IRQEN, 32'h1, rsp);
    wr(`PRP_REG_STCLR, 32'h1, rsp);
    rdc(`PRP_REG_STATUS, 32'h6);
    @(negedge mclk);
    chk(32'(irq), 32'h0);
  endtask : irq_flow
  initial begin
    nrst <= 1'h0;
    clkEn <= 1'h1;
    lineCycle <= 1'h0;
    phaseIn <= '{default: '0};
    neutralCorrectedWaveform <= '0;
    powerIn <= '{'{32'h0003_0000, '0, '0, '0}, '{'0, 32'h55, '0, '0}, '{default: '0}};
    {awaddr, araddr, wdata} <= '0;
    {awvalid, wvalid, bready, arvalid, rready} <= '0;
    wstrb <= 4'hF;
    repeat (2) @(posedge mclk);
    nrst <= 1'h1;
    reset_values();
    setup_and_sample();
    results();
    irq_flow();
    final_report();
  end
endmodule : prp_metering_tb
bind prp_metering prp_metering_properties prp_metering_properties_i (.mclk, .nrst, .clkEn,
  .awaddr, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
  .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .dspTick);
